// File: cdsp_device.sv
// Converter end: receive section sends samples, transmit section loads the
// output latch. Assumes the timer strobes and link pins are asynchronous.
`timescale 1ns/10ps
// Summary of operation
// - Separate receive and transmit sections, independent timing
// - Host uses our receive clock for sync
// - Host may clock transmit from any source
// - Gated clock: sixteen pulses, then three-state
// - First bit taken on first falling edge
// - Host holds transmit frame high between words
// - Four, five/six or three wires by mode
// - Host uses 16-bit words, falling-edge valid
// - Words move while conversion is running
// - Host flags transfer done after sixteen bits
// - External timer drives start and load strobes
// - Start rise begins conversion, frame goes low
// - Four zeros then 12-bit result, MSB first
// - Sample sixteen falling edges, keep last twelve
// - Load strobe fall copies latch, mid-word rules
module cdsp_device
   import cdsp_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   // Link pins
   cdsp_link_if.device_end           link,
   // Mode strap, level
   input  wire logic                 gated_mode_in,
   // Timer strobes
   input  wire logic                 conversion_start_in,
   input  wire logic                 output_latch_load_strobe_n_in,
   // Converter core
   input  wire logic [CODE_BITS-1:0] adc_sample_in,
   output logic                      adc_busy_out,
   output logic      [CODE_BITS-1:0] input_latch_out,
   output logic      [CODE_BITS-1:0] dac_code_out,
   output logic                      dac_update_out,
   output logic                      word_abort_out
);

   // Two-stage synchronisers for the transmit link pins and the timer strobes
   logic [SYNC_W-1:0] meta_r;
   logic [SYNC_W-1:0] sync_r;
   logic [SYNC_W-1:0] pins;

   assign pins = {link.xmit_serial_clock, link.xmit_frame_sync, link.xmit_data_in,
                  conversion_start_in, output_latch_load_strobe_n_in};

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= 5'h1f;
         sync_r <= 5'h1f;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
      end
   end

   logic s_xclk;
   logic s_xfs_n;
   logic s_xdata;
   logic s_conv;
   logic s_load_n;

   assign {s_xclk, s_xfs_n, s_xdata, s_conv, s_load_n} = sync_r;

   // Receive section: sample capture, clock divider and shifter
   cdsp_state_type           st_r, st_nxt;
   logic                     pend_r, pend_nxt;
   logic [DIV_W-1:0]         div_r, div_nxt;
   logic                     lvl_r, lvl_nxt;
   logic [WORD_BITS-1:0]     sr_r, sr_nxt;
   logic [CNT_W-1:0]         fcnt_r, fcnt_nxt;
   logic                     frame_n_r, frame_n_nxt;
   logic                     rdata_oe_r, rdata_oe_nxt;
   logic                     rclk_oe_r, rclk_oe_nxt;
   logic [CODE_BITS-1:0]     sample_r, sample_nxt;
   logic                     conv_d_r, conv_d_nxt;
   logic                     conv_rise;
   logic                     tick;

   always_comb begin
      conv_rise   = s_conv & ~conv_d_r;
      conv_d_nxt  = s_conv;
      tick        = (div_r == HALF_LAST);
      st_nxt      = st_r;
      pend_nxt    = pend_r | conv_rise;
      div_nxt     = tick ? DIV_ZERO : div_r + DIV_ONE;
      lvl_nxt     = tick ? ~lvl_r : lvl_r;
      sr_nxt      = sr_r;
      fcnt_nxt    = fcnt_r;
      frame_n_nxt = frame_n_r;
      sample_nxt  = conv_rise ? adc_sample_in : sample_r;
      unique case (st_r)
         CDSP_IDLE: begin
            // Gated clock parks high and undriven between words
            if (gated_mode_in) begin
               div_nxt = DIV_ZERO;
               lvl_nxt = 1'b1;
            end
            // Start just after a rise so the first fall is a full half later
            if (pend_r && lvl_r && div_r == DIV_ZERO) begin
               st_nxt      = CDSP_SEND;
               pend_nxt    = conv_rise;
               sr_nxt      = {LEAD_ZEROS, sample_r};
               fcnt_nxt    = CNT_ZERO;
               frame_n_nxt = 1'b0;
            end
         end
         CDSP_SEND: begin
            if (tick && lvl_r) begin
               fcnt_nxt = fcnt_r + CNT_ONE;
            end else if (tick) begin
               if (fcnt_r == WORD_END) begin
                  st_nxt      = CDSP_IDLE;
                  frame_n_nxt = 1'b1;
               end else begin
                  sr_nxt = {sr_r[WORD_BITS-2:0], 1'b0};
               end
            end
         end
      endcase
      // Open drain: pull the data line low for a zero bit
      rdata_oe_nxt = (st_nxt == CDSP_SEND) & ~sr_nxt[WORD_BITS-1];
      rclk_oe_nxt  = ~gated_mode_in | (st_nxt == CDSP_SEND);
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r       <= CDSP_IDLE;
         pend_r     <= 1'b0;
         div_r      <= DIV_ZERO;
         lvl_r      <= 1'b1;
         sr_r       <= '0;
         fcnt_r     <= CNT_ZERO;
         frame_n_r  <= 1'b1;
         rdata_oe_r <= 1'b0;
         rclk_oe_r  <= 1'b0;
         sample_r   <= '0;
         conv_d_r   <= 1'b1;
      end else begin
         st_r       <= st_nxt;
         pend_r     <= pend_nxt;
         div_r      <= div_nxt;
         lvl_r      <= lvl_nxt;
         sr_r       <= sr_nxt;
         fcnt_r     <= fcnt_nxt;
         frame_n_r  <= frame_n_nxt;
         rdata_oe_r <= rdata_oe_nxt;
         rclk_oe_r  <= rclk_oe_nxt;
         sample_r   <= sample_nxt;
         conv_d_r   <= conv_d_nxt;
      end
   end

   // Receive and transmit run from separate pins and counters
   assign link.dev_rclk_out   = lvl_r;
   assign link.dev_rclk_oe    = rclk_oe_r;
   assign link.dev_rdata_out  = 1'b0;
   assign link.dev_rdata_oe   = rdata_oe_r;
   assign link.dev_rframe_out = 1'b0;
   assign link.dev_rframe_oe  = ~frame_n_r;
   assign adc_busy_out        = (st_r == CDSP_SEND);

   // Transmit section: input shifter, input latch and output latch
   logic [WORD_BITS-1:0] xsr_r, xsr_nxt;
   logic [CNT_W-1:0]     xcnt_r, xcnt_nxt;
   logic [CODE_BITS-1:0] in_latch_r, in_latch_nxt;
   logic [CODE_BITS-1:0] out_latch_r, out_latch_nxt;
   logic                 upd_r, upd_nxt;
   logic                 abort_r, abort_nxt;
   logic                 xclk_d_r, xclk_d_nxt;
   logic                 load_d_r, load_d_nxt;
   logic                 xfall;
   logic                 load_fall;
   logic [WORD_BITS-1:0] xword;

   always_comb begin
      xclk_d_nxt    = s_xclk;
      load_d_nxt    = s_load_n;
      xfall         = xclk_d_r & ~s_xclk;
      load_fall     = load_d_r & ~s_load_n;
      xword         = {xsr_r[WORD_BITS-2:0], s_xdata};
      xsr_nxt       = xsr_r;
      xcnt_nxt      = xcnt_r;
      in_latch_nxt  = in_latch_r;
      out_latch_nxt = out_latch_r;
      upd_nxt       = 1'b0;
      abort_nxt     = 1'b0;
      if (xfall && (xcnt_r != CNT_ZERO || !s_xfs_n)) begin
         xsr_nxt  = xword;
         xcnt_nxt = xcnt_r + CNT_ONE;
         if (xcnt_r == WORD_LAST) begin
            in_latch_nxt = xword[CODE_BITS-1:0];
            xcnt_nxt     = CNT_ZERO;
            // Strobe low at word end: update now, whenever it fell
            if (!s_load_n) begin
               out_latch_nxt = xword[CODE_BITS-1:0];
               upd_nxt       = 1'b1;
            end
         end
      end else if (s_xfs_n && xcnt_r != CNT_ZERO) begin
         xcnt_nxt  = CNT_ZERO;
         abort_nxt = 1'b1;
      end else if (load_fall && xcnt_r == CNT_ZERO) begin
         // A fall in mid-word is deferred to the word end
         out_latch_nxt = in_latch_r;
         upd_nxt       = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xsr_r       <= '0;
         xcnt_r      <= CNT_ZERO;
         in_latch_r  <= '0;
         out_latch_r <= '0;
         upd_r       <= 1'b0;
         abort_r     <= 1'b0;
         xclk_d_r    <= 1'b1;
         load_d_r    <= 1'b1;
      end else begin
         xsr_r       <= xsr_nxt;
         xcnt_r      <= xcnt_nxt;
         in_latch_r  <= in_latch_nxt;
         out_latch_r <= out_latch_nxt;
         upd_r       <= upd_nxt;
         abort_r     <= abort_nxt;
         xclk_d_r    <= xclk_d_nxt;
         load_d_r    <= load_d_nxt;
      end
   end

   assign input_latch_out = in_latch_r;
   assign dac_code_out    = out_latch_r;
   assign dac_update_out  = upd_r;
   assign word_abort_out  = abort_r;

endmodule

// File: cdsp_host.sv
// Host end: synchronous serial port with a transmit FIFO.
// Assumes the converter end drives the receive pins of the link.
`timescale 1ns/10ps
module cdsp_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             rst_n_in,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   // Drain side
   output logic      [WIDTH-1:0] out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0]   CNT_FULL = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
   logic [PW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   always_comb begin
      in_ready_out  = (cnt_r != CNT_FULL);
      out_valid_out = (cnt_r != '0);
      push          = in_valid_in & in_ready_out;
      pop           = out_valid_out & out_ready_in;
      wr_nxt        = push ? ((wr_r == PTR_LAST) ? '0 : wr_r + 1'b1) : wr_r;
      rd_nxt        = pop ? ((rd_r == PTR_LAST) ? '0 : rd_r + 1'b1) : rd_r;
      cnt_nxt       = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage has no reset; only words counted as held are ever read
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem_r[wr_r] <= in_data_in;
      end
   end

   assign out_data_out = mem_r[rd_r];
endmodule

module cdsp_host
   import cdsp_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   // Link pins
   cdsp_link_if.host_end             link,
   // Mode, level: high makes the host clock and frame the transmit section
   input  wire logic                 async_mode_in,
   // Transmit words
   input  wire logic [CODE_BITS-1:0] tx_data_in,
   input  wire logic                 tx_valid_in,
   output logic                      tx_ready_out,
   // Received words and transfer done
   output logic      [CODE_BITS-1:0] rx_data_out,
   output logic                      rx_valid_out,
   output logic                      xfer_done_out
);
   logic [SYNC_W-1:0] meta_r;
   logic [SYNC_W-1:0] sync_r;
   logic              s_rclk, s_rfs_n, s_rdata, s_xclk, s_xfs_n;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= 5'h1f;
         sync_r <= 5'h1f;
      end else begin
         meta_r <= {link.recv_serial_clock, link.recv_frame_strobe, link.recv_data_out,
                    link.xmit_serial_clock, link.xmit_frame_sync};
         sync_r <= meta_r;
      end
   end

   assign {s_rclk, s_rfs_n, s_rdata, s_xclk, s_xfs_n} = sync_r;

   logic [CODE_BITS-1:0] fifo_data;
   logic                 fifo_valid;
   logic                 fifo_pop;

   cdsp_fifo #(.WIDTH(CODE_BITS), .DEPTH(FIFO_WORDS)) u_fifo (
      .core_clk_in   (core_clk_in),
      .rst_n_in      (rst_n_in),
      .in_data_in    (tx_data_in),
      .in_valid_in   (tx_valid_in),
      .in_ready_out  (tx_ready_out),
      .out_data_out  (fifo_data),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_pop)
   );

   cdsp_state_type       st_r, st_nxt;
   logic [WORD_BITS-1:0] tsr_r, tsr_nxt, rsr_r, rsr_nxt;
   logic [CNT_W-1:0]     tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt;
   logic [DIV_W-1:0]     div_r, div_nxt;
   logic                 lvl_r, lvl_nxt, tfs_n_r, tfs_n_nxt;
   logic                 rclk_d_r, xclk_d_r, xfs_d_r;
   logic [CODE_BITS-1:0] rx_r, rx_nxt;
   logic                 rxv_r, rxv_nxt, done_r, done_nxt;
   logic                 rfall, xfall, xrise, fs_fall;
   logic [WORD_BITS-1:0] rword;

   always_comb begin
      rfall    = rclk_d_r & ~s_rclk;
      xfall    = xclk_d_r & ~s_xclk;
      xrise    = ~xclk_d_r & s_xclk;
      fs_fall  = xfs_d_r & ~s_xfs_n;
      rword    = {rsr_r[WORD_BITS-2:0], s_rdata};
      // Receive: sixteen falling edges inside the frame make a word
      rsr_nxt  = rsr_r;
      rcnt_nxt = rcnt_r;
      rx_nxt   = rx_r;
      rxv_nxt  = 1'b0;
      if (s_rfs_n) begin
         rcnt_nxt = CNT_ZERO;
      end else if (rfall) begin
         rsr_nxt  = rword;
         rcnt_nxt = rcnt_r + CNT_ONE;
         if (rcnt_r == WORD_LAST) begin
            rx_nxt   = rword[CODE_BITS-1:0];
            rxv_nxt  = 1'b1;
            rcnt_nxt = CNT_ZERO;
         end
      end
      // Transmit
      st_nxt    = st_r;
      tsr_nxt   = tsr_r;
      tcnt_nxt  = tcnt_r;
      tfs_n_nxt = tfs_n_r;
      done_nxt  = 1'b0;
      fifo_pop  = 1'b0;
      div_nxt   = (div_r == HALF_LAST) ? DIV_ZERO : div_r + DIV_ONE;
      lvl_nxt   = (div_r == HALF_LAST) ? ~lvl_r : lvl_r;
      unique case (st_r)
         CDSP_IDLE: begin
            // Park only after a full low half, so the last pulse keeps its width
            if (lvl_r) begin
               div_nxt = DIV_ZERO;
               lvl_nxt = 1'b1;
            end
            // Own clock starts from its high phase, so the frame falls first
            if ((async_mode_in && fifo_valid && lvl_r) || (!async_mode_in && fs_fall)) begin
               st_nxt    = CDSP_SEND;
               fifo_pop  = fifo_valid;
               tsr_nxt   = {LEAD_ZEROS, fifo_valid ? fifo_data : {CODE_BITS{1'b0}}};
               tcnt_nxt  = CNT_ZERO;
               tfs_n_nxt = 1'b0;
            end
         end
         CDSP_SEND: begin
            if (xfall) begin
               tcnt_nxt = tcnt_r + CNT_ONE;
               if (tcnt_r == WORD_LAST) begin
                  st_nxt    = CDSP_IDLE;
                  tfs_n_nxt = 1'b1;
                  done_nxt  = 1'b1;
               end
            end else if (xrise && tcnt_r != CNT_ZERO) begin
               tsr_nxt = {tsr_r[WORD_BITS-2:0], 1'b0};
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r     <= CDSP_IDLE;
         tsr_r    <= '0;
         rsr_r    <= '0;
         tcnt_r   <= CNT_ZERO;
         rcnt_r   <= CNT_ZERO;
         div_r    <= DIV_ZERO;
         lvl_r    <= 1'b1;
         tfs_n_r  <= 1'b1;
         rclk_d_r <= 1'b1;
         xclk_d_r <= 1'b1;
         xfs_d_r  <= 1'b1;
         rx_r     <= '0;
         rxv_r    <= 1'b0;
         done_r   <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         tsr_r    <= tsr_nxt;
         rsr_r    <= rsr_nxt;
         tcnt_r   <= tcnt_nxt;
         rcnt_r   <= rcnt_nxt;
         div_r    <= div_nxt;
         lvl_r    <= lvl_nxt;
         tfs_n_r  <= tfs_n_nxt;
         rclk_d_r <= s_rclk;
         xclk_d_r <= s_xclk;
         xfs_d_r  <= s_xfs_n;
         rx_r     <= rx_nxt;
         rxv_r    <= rxv_nxt;
         done_r   <= done_nxt;
      end
   end

   // Sync mode straps transmit clock and frame to the receive ones
   assign link.host_xclk_out   = lvl_r;
   assign link.host_xclk_sel   = async_mode_in;
   assign link.host_xframe_out = tfs_n_r;
   assign link.host_xframe_sel = async_mode_in;
   assign link.host_xdata_out  = tsr_r[WORD_BITS-1];
   assign rx_data_out          = rx_r;
   assign rx_valid_out         = rxv_r;
   assign xfer_done_out        = done_r;
endmodule

// File: cdsp_link_if.sv
// Serial link between converter end and host end, with pin resolution.
// Open-drain and three-state lines are pulled high when nobody drives them.
`timescale 1ns/10ps
interface cdsp_link_if;
   logic dev_rclk_out;
   logic dev_rclk_oe;
   logic dev_rdata_out;
   logic dev_rdata_oe;
   logic dev_rframe_out;
   logic dev_rframe_oe;
   logic host_xclk_out;
   logic host_xclk_sel;
   logic host_xframe_out;
   logic host_xframe_sel;
   logic host_xdata_out;
   logic recv_serial_clock;
   logic recv_data_out;
   logic recv_frame_strobe;
   logic xmit_serial_clock;
   logic xmit_frame_sync;
   logic xmit_data_in;

   // Pull-ups on the converter's open-drain and three-state outputs
   assign recv_serial_clock = dev_rclk_oe ? dev_rclk_out : 1'b1;
   assign recv_data_out     = dev_rdata_oe ? dev_rdata_out : 1'b1;
   assign recv_frame_strobe = dev_rframe_oe ? dev_rframe_out : 1'b1;
   // Board links: host clock and frame, or the receive ones strapped across
   assign xmit_serial_clock = host_xclk_sel ? host_xclk_out : recv_serial_clock;
   assign xmit_frame_sync   = host_xframe_sel ? host_xframe_out : recv_frame_strobe;
   assign xmit_data_in      = host_xdata_out;

   modport device_end (
      output dev_rclk_out, dev_rclk_oe, dev_rdata_out, dev_rdata_oe,
      output dev_rframe_out, dev_rframe_oe,
      input  xmit_serial_clock, xmit_frame_sync, xmit_data_in
   );
   modport host_end (
      output host_xclk_out, host_xclk_sel, host_xframe_out, host_xframe_sel, host_xdata_out,
      input  recv_serial_clock, recv_data_out, recv_frame_strobe,
      input  xmit_serial_clock, xmit_frame_sync
   );
endinterface

// File: cdsp_link_sva.sv
// Checker on the link signals between converter and host ends.
// Assumes both ends run on core_clk_in and share rst_n_in.
`timescale 1ns/10ps
module cdsp_link_sva (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Link signals
   input wire logic recv_serial_clock,
   input wire logic recv_data_out,
   input wire logic recv_frame_strobe,
   input wire logic xmit_serial_clock,
   input wire logic xmit_frame_sync,
   input wire logic xmit_data_in,
   input wire logic host_xclk_out,
   input wire logic host_xclk_sel,
   input wire logic host_xframe_out,
   input wire logic dev_rframe_oe,
   input wire logic dev_rclk_oe
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [4:0] rfall_r;
   logic [4:0] xfall_r;
   // Falls inside a frame; cleared at frame start
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rfall_r <= 5'h00;
         xfall_r <= 5'h00;
      end else begin
         if ($fell(recv_frame_strobe)) rfall_r <= 5'h00;
         else if ($fell(recv_serial_clock) && !recv_frame_strobe) rfall_r <= rfall_r + 5'h01;
         if ($fell(xmit_frame_sync)) xfall_r <= 5'h00;
         else if ($fell(xmit_serial_clock) && !xmit_frame_sync) xfall_r <= xfall_r + 5'h01;
      end
   end
   sequence host_low_phase;
      !host_xclk_out [*5] ##1 host_xclk_out;
   endsequence
   rx_pulse_count_a: assert property ($rose(recv_frame_strobe) |-> rfall_r == 5'h10)
      else $error("receive frame did not hold sixteen clock falls");
   lead_zeros_a: assert property ($fell(recv_serial_clock) && !recv_frame_strobe
      && rfall_r < 5'h04 |-> !recv_data_out) else $error("leading bit not zero");
   rx_data_hold_a: assert property (!recv_frame_strobe && !recv_serial_clock
      && !$past(recv_serial_clock) |-> $stable(recv_data_out)) else $error("data moved while low");
   frame_start_a: assert property ($fell(recv_frame_strobe) |-> recv_serial_clock && dev_rclk_oe)
      else $error("frame fell with clock low or undriven");
   clock_in_frame_a: assert property (dev_rframe_oe |-> dev_rclk_oe)
      else $error("receive clock undriven inside frame");
   host_half_a: assert property (host_xclk_sel && $fell(host_xclk_out) |-> host_low_phase)
      else $error("host clock low phase not five cycles");
   tx_pulse_count_a: assert property ($rose(xmit_frame_sync) |-> xfall_r == 5'h10)
      else $error("transmit frame did not hold sixteen clock falls");
   tx_data_hold_a: assert property (!xmit_frame_sync && !xmit_serial_clock
      && !$past(xmit_serial_clock) |-> $stable(xmit_data_in)) else $error("tx data moved while low");
   host_frame_a: assert property (host_xclk_sel && $fell(host_xframe_out) |-> host_xclk_out)
      else $error("host frame began with clock low");
endmodule

// File: cdsp_pkg.sv
// Shared constants and types for the converter serial port, both ends.
// Assumes a single core clock at the rate below on each end.
package cdsp_pkg;
   localparam int CORE_CLK_PERIOD_PS = 8000;
   localparam int LINK_CLK_PERIOD_NS = 80;
   localparam int LINK_HALF_CYCLES   = (LINK_CLK_PERIOD_NS * 1000 / 2) / CORE_CLK_PERIOD_PS;
   localparam int WORD_BITS          = 16;
   localparam int LEAD_BITS          = 4;
   localparam int CODE_BITS          = 12;
   localparam int FIFO_WORDS         = 8;
   localparam int CNT_W              = 5;
   localparam int DIV_W              = 4;
   localparam int SYNC_W             = 5;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
   localparam logic [CNT_W-1:0] WORD_LAST = 5'h0f;
   localparam logic [CNT_W-1:0] WORD_END  = 5'h10;
   localparam logic [DIV_W-1:0] DIV_ZERO  = 4'h0;
   localparam logic [DIV_W-1:0] DIV_ONE   = 4'h1;
   localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(LINK_HALF_CYCLES - 1);
   localparam logic [LEAD_BITS-1:0] LEAD_ZEROS = 4'h0;
   typedef enum logic {CDSP_IDLE, CDSP_SEND} cdsp_state_type;
endpackage

// File: converter_dsp_serial_port_tb_top.sv
// Bench joining converter and host ends over one link interface.
// Assumes one shared core clock; drivers queue expectations, a monitor pops.
`timescale 1ns/10ps
module converter_dsp_serial_port_tb_top;
   import cdsp_pkg::*;
   logic                 core_clk_in, rst_n_in, gated_mode_in, async_mode_in;
   logic                 conversion_start_in, output_latch_load_strobe_n_in, tx_valid_in;
   logic                 tx_ready_out, rx_valid_out, dac_update_out, adc_busy_out;
   logic                 word_abort_out, xfer_done_out;
   logic [CODE_BITS-1:0] adc_sample_in, tx_data_in, input_latch_out, dac_code_out, rx_data_out;
   logic [CODE_BITS-1:0] rx_q[$];
   logic [CODE_BITS-1:0] dac_q[$];
   logic [CODE_BITS-1:0] last_w;
   int                   mismatches, comparisons, cycles, dones;
   cdsp_link_if cdsp_link_if_i ();
   cdsp_device cdsp_device_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .link(cdsp_link_if_i), .gated_mode_in(gated_mode_in),
      .conversion_start_in(conversion_start_in),
      .output_latch_load_strobe_n_in(output_latch_load_strobe_n_in),
      .adc_sample_in(adc_sample_in), .adc_busy_out(adc_busy_out),
      .input_latch_out(input_latch_out), .dac_code_out(dac_code_out),
      .dac_update_out(dac_update_out), .word_abort_out(word_abort_out));
   cdsp_host cdsp_host_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .link(cdsp_link_if_i), .async_mode_in(async_mode_in), .tx_data_in(tx_data_in),
      .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out), .rx_data_out(rx_data_out),
      .rx_valid_out(rx_valid_out), .xfer_done_out(xfer_done_out));
   cdsp_link_sva cdsp_link_sva_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .recv_serial_clock(cdsp_link_if_i.recv_serial_clock),
      .recv_data_out(cdsp_link_if_i.recv_data_out),
      .recv_frame_strobe(cdsp_link_if_i.recv_frame_strobe),
      .xmit_serial_clock(cdsp_link_if_i.xmit_serial_clock),
      .xmit_frame_sync(cdsp_link_if_i.xmit_frame_sync),
      .xmit_data_in(cdsp_link_if_i.xmit_data_in),
      .host_xclk_out(cdsp_link_if_i.host_xclk_out),
      .host_xclk_sel(cdsp_link_if_i.host_xclk_sel),
      .host_xframe_out(cdsp_link_if_i.host_xframe_out),
      .dev_rframe_oe(cdsp_link_if_i.dev_rframe_oe), .dev_rclk_oe(cdsp_link_if_i.dev_rclk_oe));
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end
   task automatic check(input string name, input logic [CODE_BITS-1:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Note off: the word is expected only at a later strobe fall
   task automatic push(input int n, input bit note);
      logic [CODE_BITS-1:0] w;
      for (int k = 0; k < n; k++) begin
         w = CODE_BITS'($urandom);
         tx_data_in <= w;
         tx_valid_in <= 1'b1;
         @(negedge core_clk_in);
         while (tx_ready_out !== 1'b1) @(negedge core_clk_in);
         @(posedge core_clk_in);
         if (note) dac_q.push_back(w);
         last_w = w;
      end
      tx_valid_in <= 1'b0;
   endtask
   task automatic conv();
      logic [CODE_BITS-1:0] s;
      s = CODE_BITS'($urandom);
      rx_q.push_back(s);
      adc_sample_in <= s;
      conversion_start_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      conversion_start_in <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic drain();
      for (int i = 0; i < 3000 && (rx_q.size() + dac_q.size()) > 0; i++) @(posedge core_clk_in);
      check("pending", CODE_BITS'(rx_q.size() + dac_q.size()), 12'h000);
   endtask
   // Every result that appears must match the oldest note
   always @(negedge core_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
      if (rx_valid_out === 1'b1) begin
         if (rx_q.size() == 0) check("rx_valid_out", 12'h001, 12'h000);
         else check("rx_data_out", rx_data_out, rx_q.pop_front());
      end
      if (dac_update_out === 1'b1) begin
         if (dac_q.size() == 0) check("dac_update_out", 12'h001, 12'h000);
         else check("dac_code_out", dac_code_out, dac_q.pop_front());
      end
      if (cdsp_link_if_i.recv_frame_strobe === 1'b0) begin
         check("adc_busy_out", CODE_BITS'(adc_busy_out), 12'h001);
      end
      if (word_abort_out === 1'b1) check("word_abort_out", 12'h001, 12'h000);
      if (xfer_done_out === 1'b1) dones++;
   end
   initial begin
      rst_n_in = 1'b0;
      gated_mode_in = 1'b1;
      async_mode_in = 1'b0;
      conversion_start_in = 1'b0;
      output_latch_load_strobe_n_in = 1'b1;
      adc_sample_in = 12'h000;
      tx_data_in = 12'h000;
      tx_valid_in = 1'b0;
      mismatches = 0;
      comparisons = 0;
      cycles = 0;
      dones = 0;
      void'($urandom(37));
      repeat (4) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      // Strobe fall outside a word copies the cleared input latch
      dac_q.push_back(12'h000);
      output_latch_load_strobe_n_in <= 1'b0;
      repeat (10) @(posedge core_clk_in);
      // No frames yet, so the buffer fills until it refuses
      push(FIFO_WORDS, 1'b1);
      @(negedge core_clk_in);
      check("tx_ready_out", CODE_BITS'(tx_ready_out), 12'h000);
      @(posedge core_clk_in);
      // Gated clock, strapped sync; second start lands mid-word
      for (int i = 0; i < FIFO_WORDS / 2; i++) begin
         conv();
         repeat (30) @(posedge core_clk_in);
         conv();
         repeat (420) @(posedge core_clk_in);
      end
      drain();
      // Continuous clock; strobe high over the word, so no update until it falls
      gated_mode_in <= 1'b0;
      output_latch_load_strobe_n_in <= 1'b1;
      repeat (20) @(posedge core_clk_in);
      push(1, 1'b0);
      conv();
      drain();
      repeat (40) @(posedge core_clk_in);
      check("input_latch_out", input_latch_out, last_w);
      dac_q.push_back(last_w);
      output_latch_load_strobe_n_in <= 1'b0;
      repeat (20) @(posedge core_clk_in);
      drain();
      // Host clocks transmit on its own while conversions run
      async_mode_in <= 1'b1;
      repeat (20) @(posedge core_clk_in);
      push(3, 1'b1);
      for (int i = 0; i < 3; i++) begin
         conv();
         repeat (250) @(posedge core_clk_in);
      end
      drain();
      check("xfer_done_out", CODE_BITS'(dones), 12'h00c);
      complete_run();
   end
endmodule
